/* design/urb_pkg.sv */
// package: constants and types for the receive buffer and status block
package urb_pkg;
  // character size codes on char_size_field (5..8 bits, 9 bits)
  localparam logic [2:0] SIZE_5 = 3'h0;
  localparam logic [2:0] SIZE_6 = 3'h1;
  localparam logic [2:0] SIZE_7 = 3'h2;
  localparam logic [2:0] SIZE_8 = 3'h3;
  localparam logic [2:0] SIZE_9 = 3'h7;
  // receive buffer depth in characters
  localparam int BUF_DEPTH = 2;
  // reset values
  localparam logic [1:0] CNT_RESET = 2'h0;
  localparam logic [8:0] DATA_RESET = 9'h000;
  // frame reception states
  typedef enum logic [1:0] {urb_idle, urb_data, urb_par, urb_stop} urb_state_e;
endpackage

/* design/urb_receiver.sv */
// receive shift register, two-entry buffer, error flags and interrupt request
// How it works
// - complete flag high while buffer holds characters
// - disabling receiver empties the buffer
// - irq equals enable and flag and global
// - data read pops oldest buffered character
// - error bits stored per character in buffer
// - error flags cannot be written by software
// - error flags never raise an interrupt
// - frame error equals first stop bit zero
// - only first stop bit checked for framing
// - overrun when buffer full, shifter full, start
// - overrun cleared on successful buffer transfer
// - parity check only when enabled, odd selectable
// - parity mismatch stored with the character
// - parity error needs mismatch and enabled check
// - parity error reads zero when check off
// - disable aborts frame in progress at once
// - pin override released while receiver disabled
// - ninth bit presented before data read
// - unused upper data bits read as zero
// - first stop bit moves shifter to holding stage
`timescale 1ns/1ps
module urb_receiver #(
  parameter int DEPTH = urb_pkg::BUF_DEPTH  // buffer entries
)(
  input  wire logic       clk,                    // system clock
  input  wire logic       reset,                  // async reset, high
  input  wire logic       receiver_enable_bit,    // receiver on
  input  wire logic       rx_complete_irq_enable, // irq enable
  input  wire logic       global_irq_enable,      // global irq enable
  input  wire logic       parity_enable_bit,      // parity check on
  input  wire logic       parity_odd_select,      // 1 odd, 0 even
  input  wire logic       stop_bits_select,       // ignored on receive
  input  wire logic [2:0] char_size_field,        // character size code
  input  wire logic       bit_valid,              // recovered bit strobe
  input  wire logic       bit_value,              // recovered bit level
  input  wire logic       start_detect,           // valid start bit pulse
  input  wire logic       data_read,              // data register read pulse
  output logic            receive_complete_flag,  // unread data present
  output logic            rx_complete_irq,        // interrupt request
  output logic            frame_error_flag,       // oldest char stop bit 0
  output logic            overrun_flag,           // data lost before oldest
  output logic            parity_error_flag,      // oldest char parity bad
  output logic            ninth_rx_bit,           // ninth bit of oldest
  output logic [7:0]      read_data,              // low data bits of oldest
  output logic            pin_override            // receive_pin taken over
);
  // the single-bit read pointer only serves a depth of two
  if (DEPTH != 2)
    $error("urb_receiver: buffer depth must be 2");

  // one buffered character with its status
  typedef struct packed {
    logic [8:0] data;
    logic       fe;
    logic       dor;
    logic       pe;
  } urb_entry_s;

  // all state of the block
  typedef struct packed {
    urb_pkg::urb_state_e st;       // frame state
    logic [3:0]          bitn;     // data bits received
    logic [8:0]          shift;    // shift register
    logic                parity;   // running xor of data bits
    logic                pbad;     // parity mismatch of this frame
    logic                pchk;     // check enabled at reception
    logic                held;     // completed char waiting in shifter
    urb_entry_s          held_e;   // that character
    logic                lost;     // overrun pending for next transfer
    urb_entry_s [1:0]    buf_e;    // buffer entries
    logic                rd_ptr;   // oldest entry
    logic [1:0]          count;    // characters buffered
  } urb_s;

  urb_s cur;       // registered state
  urb_s next_cur;  // next state
  urb_entry_s head;     // oldest entry
  urb_entry_s new_e;    // entry being completed
  logic [3:0] nbits;    // bits per character
  logic       pop;      // buffer read accepted
  logic       push;     // shifter to buffer

  // character width decode
  always_comb
  begin
    if (char_size_field == urb_pkg::SIZE_9)
      nbits = 4'h9;
    else
      nbits = 4'h5 + {2'h0, char_size_field[1:0]};
  end

  assign head = cur.buf_e[cur.rd_ptr];

  // next-state logic
  always_comb
  begin
    next_cur = cur;
    new_e    = '0;
    push     = 1'b0;
    pop      = data_read && (cur.count != urb_pkg::CNT_RESET);
    if (pop)
    begin
      next_cur.rd_ptr = ~cur.rd_ptr;
    end
    // frame shifting
    case (cur.st)
      urb_pkg::urb_idle:
      begin
        if (start_detect)
        begin
          // full buffer plus waiting char: the new frame overruns
          if (cur.held && cur.count == 2'h2 && !pop)
            next_cur.lost = 1'b1;
          next_cur.st     = urb_pkg::urb_data;
          next_cur.bitn   = 4'h0;
          next_cur.shift  = urb_pkg::DATA_RESET;
          next_cur.parity = parity_odd_select;
          next_cur.pchk   = parity_enable_bit;
        end
      end
      urb_pkg::urb_data:
      begin
        if (bit_valid)
        begin
          next_cur.shift[cur.bitn] = bit_value;  // lsb first, upper stay zero
          next_cur.parity = cur.parity ^ bit_value;
          next_cur.bitn   = cur.bitn + 4'h1;
          if (cur.bitn + 4'h1 == nbits)
            next_cur.st = cur.pchk ? urb_pkg::urb_par : urb_pkg::urb_stop;
        end
      end
      urb_pkg::urb_par:
      begin
        if (bit_valid)
        begin
          next_cur.pbad = cur.parity ^ bit_value;
          next_cur.st   = urb_pkg::urb_stop;
        end
      end
      default:
      begin
        // only the first stop bit is looked at
        if (bit_valid)
        begin
          new_e.data = cur.shift;
          new_e.fe   = ~bit_value;
          new_e.pe   = cur.pchk & cur.pbad;
          next_cur.held   = 1'b1;
          next_cur.held_e = new_e;
          next_cur.pbad   = 1'b0;
          next_cur.st     = urb_pkg::urb_idle;
        end
      end
    endcase
    // move the waiting character when a slot is free
    if (cur.held && (cur.count != 2'h2 || pop))
    begin
      push = 1'b1;
      next_cur.buf_e[cur.rd_ptr ^ cur.count[0]] = cur.held_e;
      next_cur.buf_e[cur.rd_ptr ^ cur.count[0]].dor = cur.lost;
      next_cur.lost = 1'b0;
      if (!(cur.st == urb_pkg::urb_stop && bit_valid))
        next_cur.held = 1'b0;
    end
    next_cur.count = cur.count + {1'b0, push} - {1'b0, pop};
    // disabling flushes and aborts at once
    if (!receiver_enable_bit)
    begin
      next_cur.st    = urb_pkg::urb_idle;
      next_cur.held  = 1'b0;
      next_cur.lost  = 1'b0;
      next_cur.count = urb_pkg::CNT_RESET;
      next_cur.pbad  = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cur <= '0;
    else
      cur <= next_cur;
  end

  // outputs; error bits only come from the buffer, no write path
  assign receive_complete_flag = (cur.count != urb_pkg::CNT_RESET);
  assign rx_complete_irq = rx_complete_irq_enable & global_irq_enable
                           & receive_complete_flag;
  assign frame_error_flag  = receive_complete_flag & head.fe;
  assign overrun_flag      = receive_complete_flag & head.dor;
  assign parity_error_flag = receive_complete_flag & head.pe & parity_enable_bit;
  // data is masked while empty so a stale entry never leaks out
  assign ninth_rx_bit      = receive_complete_flag & head.data[8];
  assign read_data         = {8{receive_complete_flag}} & head.data[7:0];
  assign pin_override      = receiver_enable_bit;

  // checks on the state and outputs of this block
  // every property runs on the system clock and sleeps during reset
  // they look at what the block drives, at its enable and read inputs, and at the far-side strobes bit_valid, bit_value and start_detect

  // the flag may only rise after a character waited in the shifter
  chk_flag_rise: assert property (@(posedge clk) disable iff (reset)
    $rose(receive_complete_flag) |-> $past(cur.held))
    else $error("complete flag rose without a transfer");

  // a cleared enable empties the buffer on the next edge
  chk_disable_flush: assert property (@(posedge clk) disable iff (reset)
    !receiver_enable_bit |=> !receive_complete_flag)
    else $error("buffer not flushed on disable");

  // request is a plain level of the three terms
  chk_irq_level: assert property (@(posedge clk) disable iff (reset)
    rx_complete_irq == (rx_complete_irq_enable && global_irq_enable
                        && receive_complete_flag))
    else $error("irq mismatch");

  // reading the last character empties the buffer
  chk_read_pops: assert property (@(posedge clk) disable iff (reset)
    data_read && cur.count == 2'h1 && !cur.held && receiver_enable_bit
    |=> !receive_complete_flag)
    else $error("read did not pop");

  // error status only exists for a buffered character
  chk_err_empty: assert property (@(posedge clk) disable iff (reset)
    !receive_complete_flag |-> !frame_error_flag && !overrun_flag && !parity_error_flag)
    else $error("error flag with empty buffer");

  // an error without a character never requests service
  chk_no_err_irq: assert property (@(posedge clk) disable iff (reset)
    !receive_complete_flag |-> !rx_complete_irq)
    else $error("irq without a character");

  // the first stop bit alone decides the frame error
  chk_stop_capture: assert property (@(posedge clk) disable iff (reset)
    cur.st == urb_pkg::urb_stop && bit_valid && receiver_enable_bit
    |=> cur.held && cur.held_e.fe == !$past(bit_value))
    else $error("stop bit not captured");

  // full buffer, waiting char and a new start mark an overrun
  chk_overrun_mark: assert property (@(posedge clk) disable iff (reset)
    cur.st == urb_pkg::urb_idle && start_detect && cur.held
    && cur.count == 2'h2 && !data_read && receiver_enable_bit
    |=> cur.lost)
    else $error("overrun not marked");

  // a successful move into the buffer consumes the overrun mark
  chk_lost_clear: assert property (@(posedge clk) disable iff (reset)
    push && receiver_enable_bit |=> !cur.lost)
    else $error("overrun mark not cleared");

  // the parity bit is compared with the running xor
  chk_parity_store: assert property (@(posedge clk) disable iff (reset)
    cur.st == urb_pkg::urb_par && bit_valid && receiver_enable_bit
    |=> cur.pbad == ($past(cur.parity) ^ $past(bit_value)))
    else $error("parity result not stored");

  // a frame taken with checking off never carries a parity error
  chk_pe_needs_check: assert property (@(posedge clk) disable iff (reset)
    cur.st == urb_pkg::urb_stop && bit_valid && receiver_enable_bit && !cur.pchk
    |=> !cur.held_e.pe)
    else $error("parity error stored while unchecked");

  // the live enable masks the flag
  chk_pe_off: assert property (@(posedge clk) disable iff (reset)
    !parity_enable_bit |-> !parity_error_flag)
    else $error("parity error while checking off");

  // disabling drops the frame in progress at once
  chk_abort_frame: assert property (@(posedge clk) disable iff (reset)
    !receiver_enable_bit |=> cur.st == urb_pkg::urb_idle && !cur.held)
    else $error("frame not aborted");

  // pin is only taken over while receiving is on
  chk_pin_release: assert property (@(posedge clk) disable iff (reset)
    pin_override == receiver_enable_bit)
    else $error("pin override wrong");

  // two entries at most; a fourth would wrap the count
  chk_no_overflow: assert property (@(posedge clk) disable iff (reset)
    cur.count <= 2'h2)
    else $error("buffer count overflow");

  // main scenarios that the bench is expected to reach
  cov_fill_two: cover property (@(posedge clk) disable iff (reset) cur.count == 2'h2);
  cov_overrun: cover property (@(posedge clk) disable iff (reset) overrun_flag);
  cov_parity: cover property (@(posedge clk) disable iff (reset) parity_error_flag);
  cov_frame_error: cover property (@(posedge clk) disable iff (reset) frame_error_flag);
  cov_abort: cover property (@(posedge clk) disable iff (reset)
    !receiver_enable_bit && cur.st != urb_pkg::urb_idle);
endmodule

/* sim/urb_far_tx.sv */
// behavioural far-end transmitter giving start and recovered bit strobes
`timescale 1ns/1ps
module urb_far_tx (
  input  wire logic clk,
  output logic      start_detect,
  output logic      bit_valid,
  output logic      bit_value
);
  // idle line: no strobes
  initial
  begin
    start_detect = 1'b0;
    bit_valid = 1'b0;
    bit_value = 1'b1;
  end
  // one frame: data lsb first, parity if on, first stop bit only
  task automatic send(input logic [8:0] d, input int n, input logic pe, input logic pb,
                      input logic stop, input int gap);
    logic q[$];
    for (int k = 0; k < n; k++)
      q.push_back(d[k]);
    if (pe)
      q.push_back(pb);
    q.push_back(stop);
    @(posedge clk);
    start_detect <= 1'b1;
    @(posedge clk);
    start_detect <= 1'b0;
    foreach (q[k])
    begin
      bit_valid <= 1'b1;
      bit_value <= q[k];
      @(posedge clk);
      // released line shows the inverse so a stale level never passes
      if (gap > 0 || k == q.size() - 1)
      begin
        bit_valid <= 1'b0;
        bit_value <= ~q[k];
        repeat (gap) @(posedge clk);
      end
    end
  endtask
endmodule

/* sim/test_urb_receiver.sv */
// self-checking bench for the receive buffer and status block
`timescale 1ns/1ps
module test_urb_receiver;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        en, ie, gie, pen, podd, sbs, rd, sd, bv, bval;
  logic        rcf, irq, fe, dor, pe, b9, povr, hv, dp;
  logic [2:0]  csz;
  logic [2:0]  sizes [5];
  logic [7:0]  rdat;
  logic [11:0] mq[$];  // model buffer: pe, dor, fe, ninth, data
  logic [11:0] held;   // model shift-holding stage
  int          miscompares = 0;
  int          num_checks = 0;
  int          gap = 0;
  always #4 clk = ~clk;
  urb_receiver i_urb_receiver (.clk(clk), .reset(reset), .receiver_enable_bit(en),
    .rx_complete_irq_enable(ie), .global_irq_enable(gie), .parity_enable_bit(pen),
    .parity_odd_select(podd), .stop_bits_select(sbs), .char_size_field(csz),
    .bit_valid(bv), .bit_value(bval), .start_detect(sd), .data_read(rd),
    .receive_complete_flag(rcf), .rx_complete_irq(irq), .frame_error_flag(fe),
    .overrun_flag(dor), .parity_error_flag(pe), .ninth_rx_bit(b9), .read_data(rdat),
    .pin_override(povr));
  urb_far_tx i_urb_far_tx (.clk(clk), .start_detect(sd), .bit_valid(bv), .bit_value(bval));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // held character moves on once the buffer has room
  task automatic xfer();
    if (hv && mq.size() < 2)
    begin
      mq.push_back(held | {1'b0, dp, 10'h0});
      hv = 1'b0;
      dp = 1'b0;
    end
  endtask
  // status before data; parity flag gated by the live enable
  task automatic look();
    logic [11:0] e;
    e = (mq.size() > 0) ? mq[0] : 12'h000;
    e[11] = e[11] & pen;
    // no status write port exists, so software never writes the error bits
    chk({pe, dor, fe, b9, rdat}, e);
    chk({9'h0, rcf, irq, povr},
        {9'h0, mq.size() > 0, ie & gie & (mq.size() > 0), en});
  endtask
  task automatic pop();
    look();
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    if (mq.size() > 0)
      void'(mq.pop_front());
    xfer();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // bp spoils parity, bs spoils the stop bit
  task automatic frame(input logic [8:0] d, input logic bp, input logic bs, input int w);
    int n;
    logic [8:0] m;
    n = (csz == urb_pkg::SIZE_9) ? 9 : int'(csz) + 5;
    m = d & 9'((1 << n) - 1);
    if (mq.size() == 2 && hv)
      dp = 1'b1;
    i_urb_far_tx.send(m, n, pen, (^m) ^ podd ^ bp, ~bs, gap);
    held = {pen & bp, 1'b0, bs, m};
    hv = 1'b1;
    repeat (w) @(posedge clk);
    #1;
    xfer();
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    {en, ie, gie, pen, podd, sbs, rd} = 7'h0;
    csz = urb_pkg::SIZE_8;
    {hv, dp} = 2'h0;
    sizes = '{urb_pkg::SIZE_5, urb_pkg::SIZE_6, urb_pkg::SIZE_7, urb_pkg::SIZE_8,
              urb_pkg::SIZE_9};
    void'($urandom(32'h1dc9eac6));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    en <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      csz <= sizes[i % 5];
      {ie, gie, pen, podd, sbs} <= 5'($urandom);
      #1;
      gap = $urandom % 3;
      frame(9'($urandom), ($urandom % 4) == 0, ($urandom % 4) == 0, 3);
      pop();
    end
    $display("random frames done");
    // parity flag follows the live enable while the char waits
    @(posedge clk);
    pen <= 1'b1;
    gap = 0;
    #1;
    frame(9'h0a7, 1'b1, 1'b0, 3);
    @(posedge clk);
    pen <= 1'b0;
    #1;
    look();
    @(posedge clk);
    pen <= 1'b1;
    #1;
    pop();
    // back to back, a third waits, a fourth overwrites it and carries the overrun
    @(posedge clk);
    pen <= 1'b0;
    csz <= urb_pkg::SIZE_9;
    #1;
    frame(9'h1a5, 1'b0, 1'b0, 0);
    frame(9'h05a, 1'b0, 1'b1, 3);
    frame(9'h0ff, 1'b0, 1'b0, 3);
    frame(9'h100, 1'b0, 1'b0, 3);
    for (int k = 0; k < 5 && rcf === 1'b1; k++)
      pop();
    look();
    $display("overrun done");
    // disable mid-frame with a char waiting
    frame(9'h033, 1'b0, 1'b0, 3);
    fork
      i_urb_far_tx.send(9'h0cc, 9, 1'b0, 1'b0, 1'b1, 0);
      begin
        repeat (4) @(posedge clk);
        en <= 1'b0;
        mq.delete();
        {hv, dp} = 2'h0;
        @(posedge clk);
        #1;
        look();
        @(posedge clk);
        en <= 1'b1;
      end
    join
    repeat (4) @(posedge clk);
    #1;
    look();
    $display("disable done");
    final_report();
  end
  // hang guard
  initial
  begin
    #400000;
    miscompares++;
    final_report();
  end
endmodule
